/* File: lpw_regs.vh */
// How it works
// - upper virtual bits must copy bit 47
// - bits 47..39 index top table
// - bits 38..30 index pointer table
// - bits 29..21 index directory table
// - 2M offset is virtual bits 20..0
// - 1G offset is virtual bits 29..0
// - 2M walk never fetches leaf entry
// - directory entry bit7 set ends at 2M
// - 1G walk fetches no directory entry
// - pointer entry bit7 set ends at 1G
// - giga support reported at query bit 26
// - query reports giga TLB entry counts
// - base fields to bit 51, unimplemented masked
// - page base low bits taken as zero
// - non-present entry raises page fault
// - non-canonical address raises protection fault
// - size bit set in a pointer or directory entry ends descent there
`ifndef LPW_REGS_VH
`define LPW_REGS_VH

// register byte offsets, decoded from haddr[7:0]
`define LPW_OFS_CTRL 8'h00
`define LPW_OFS_BASE_LO 8'h04
`define LPW_OFS_BASE_HI 8'h08
`define LPW_OFS_VA_LO 8'h0C
`define LPW_OFS_VA_HI 8'h10
`define LPW_OFS_PA_LO 8'h14
`define LPW_OFS_PA_HI 8'h18
`define LPW_OFS_STATUS 8'h1C
`define LPW_OFS_INT_STAT 8'h20
`define LPW_OFS_INT_MASK 8'h24
`define LPW_OFS_QRY_FOURTH 8'h28
`define LPW_OFS_QRY_FIRST 8'h2C
`define LPW_OFS_QRY_SECOND 8'h30

// control fields
`define LPW_CTRL_START 0
`define LPW_CTRL_GIGA_EN 1
`define LPW_GIGA_EN_RST 1'b1

// virtual address fields
`define LPW_VA_TOP 63
`define LPW_VA_SIGN 47
`define LPW_TOP_HI 47
`define LPW_TOP_LO 39
`define LPW_PTR_HI 38
`define LPW_PTR_LO 30
`define LPW_DIR_HI 29
`define LPW_DIR_LO 21
`define LPW_OFF2M_HI 20
`define LPW_OFF1G_HI 29

// entry fields
`define LPW_ENT_PRESENT 0
`define LPW_ENT_SIZE 7
`define LPW_ENT_BASE_HI 51
`define LPW_ENT_TBL_LO 12
`define LPW_ENT_2M_LO 21
`define LPW_ENT_1G_LO 30

// implemented physical address bits (48 of 52)
`define LPW_PA_MASK 52'h0_FFFF_FFFF_FFFF

// identification query contents
`define LPW_GIGA_SUPPORT 1'b1
`define LPW_FEAT_GIGA_BIT 26
`define LPW_TLB_L1_GIGA 32'h0000_0010
`define LPW_TLB_L2_GIGA 32'h0000_0200

// fault codes in status
`define LPW_FLT_NONE 4'h0
`define LPW_FLT_PAGE 4'h1
`define LPW_FLT_GPROT 4'h2
`define LPW_FLT_SMALL 4'h3

// interrupt status bits
`define LPW_INT_DONE 0
`define LPW_INT_PAGE 1
`define LPW_INT_GPROT 2
`define LPW_INT_SMALL 3
`define LPW_INT_W 4

// walk levels reported with a fault
`define LPW_LVL_TOP 2'h3
`define LPW_LVL_PTR 2'h2
`define LPW_LVL_DIR 2'h1
`define LPW_LVL_NONE 2'h0

`endif

/* File: lpw_va_split.v */
`timescale 1ns/10ps
`include "lpw_regs.vh"

module lpw_va_split (
    // virtual address in
    input wire [63:0] va,
    // table indices
    output wire [8:0] topIdx,
    output wire [8:0] ptrIdx,
    output wire [8:0] dirIdx,
    // page offsets
    output wire [20:0] off2m,
    output wire [29:0] off1g,
    // canonical check
    output wire canonical
);
    assign topIdx = va[`LPW_TOP_HI:`LPW_TOP_LO];
    assign ptrIdx = va[`LPW_PTR_HI:`LPW_PTR_LO];
    assign dirIdx = va[`LPW_DIR_HI:`LPW_DIR_LO];
    assign off2m = va[`LPW_OFF2M_HI:0];
    assign off1g = va[`LPW_OFF1G_HI:0];
    // bits 63..47 all equal
    assign canonical = (&va[`LPW_VA_TOP:`LPW_VA_SIGN]) | ~(|va[`LPW_VA_TOP:`LPW_VA_SIGN]);
endmodule // lpw_va_split

/* File: lpw_walker.v */
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`include "lpw_regs.vh"

module lpw_walker (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    // translation table memory
    output wire memReq,
    output wire [51:0] memAddr,
    input wire memAck,
    input wire [63:0] memRdata,
    // interrupt
    output wire irq
);
    localparam S_IDLE = 4'h1;
    localparam S_TOP = 4'h2;
    localparam S_PTR = 4'h4;
    localparam S_DIR = 4'h8;

    // bus state
    reg wrPend_q;
    reg [7:0] wrAddr_q;
    reg [31:0] hrdata_q;
    reg [31:0] rdMux;
    // software registers
    reg gigaEn_q;
    reg [39:0] base_q;
    reg [63:0] va_q;
    reg [`LPW_INT_W-1:0] intStat_q;
    reg [`LPW_INT_W-1:0] intMask_q;
    // walk state
    reg [3:0] state_q;
    reg memReq_q;
    reg [51:0] memAddr_q;
    reg [51:0] pa_q;
    reg done_q;
    reg size2m_q;
    reg size1g_q;
    reg [3:0] fault_q;
    reg [1:0] faultLvl_q;
    // events of this cycle
    reg evDone;
    reg evPage;
    reg evGprot;
    reg evSmall;

    // interrupt events and their next sticky state
    wire [`LPW_INT_W-1:0] intEvent;
    wire [`LPW_INT_W-1:0] intStat_d;
    genvar gi;

    wire [8:0] topIdx;
    wire [8:0] ptrIdx;
    wire [8:0] dirIdx;
    wire [20:0] off2m;
    wire [29:0] off1g;
    wire canonical;

    lpw_va_split uSplit (
        .va(va_q),
        .topIdx(topIdx),
        .ptrIdx(ptrIdx),
        .dirIdx(dirIdx),
        .off2m(off2m),
        .off1g(off1g),
        .canonical(canonical)
    );

    wire addrPhase = hsel & htrans[1] & hready;
    wire busy = (state_q != S_IDLE);
    wire wrCtrl = wrPend_q & (wrAddr_q == `LPW_OFS_CTRL);
    // start refused while a walk runs
    wire startPulse = wrCtrl & hwdata[`LPW_CTRL_START] & ~busy;
    wire intRdClr = addrPhase & ~hwrite & (haddr[7:0] == `LPW_OFS_INT_STAT);
    wire gigaOk = `LPW_GIGA_SUPPORT & gigaEn_q;
    wire present = memRdata[`LPW_ENT_PRESENT];
    wire sizeBit = memRdata[`LPW_ENT_SIZE];
    // next table address, unimplemented bits dropped
    wire [51:0] nextPtr = {memRdata[`LPW_ENT_BASE_HI:`LPW_ENT_TBL_LO], ptrIdx, 3'h0} & `LPW_PA_MASK;
    wire [51:0] nextDir = {memRdata[`LPW_ENT_BASE_HI:`LPW_ENT_TBL_LO], dirIdx, 3'h0} & `LPW_PA_MASK;
    // final addresses: page base low bits ignored, offset passed through
    wire [51:0] pa1g = {memRdata[`LPW_ENT_BASE_HI:`LPW_ENT_1G_LO], off1g} & `LPW_PA_MASK;
    wire [51:0] pa2m = {memRdata[`LPW_ENT_BASE_HI:`LPW_ENT_2M_LO], off2m} & `LPW_PA_MASK;
    wire [31:0] statusWord = {22'h0, faultLvl_q, fault_q, size1g_q, size2m_q, done_q, busy};
    wire [31:0] featWord = {31'h0, `LPW_GIGA_SUPPORT} << `LPW_FEAT_GIGA_BIT;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign memReq = memReq_q;
    assign memAddr = memAddr_q;
    assign irq = |(intStat_q & intMask_q);

    // read mux, unmapped reads zero
    always @* begin
        case (haddr[7:0])
            `LPW_OFS_CTRL: rdMux = {30'h0, gigaEn_q, 1'b0};
            `LPW_OFS_BASE_LO: rdMux = {base_q[19:0], 12'h000};
            `LPW_OFS_BASE_HI: rdMux = {12'h000, base_q[39:20]};
            `LPW_OFS_VA_LO: rdMux = va_q[31:0];
            `LPW_OFS_VA_HI: rdMux = va_q[63:32];
            `LPW_OFS_PA_LO: rdMux = pa_q[31:0];
            `LPW_OFS_PA_HI: rdMux = {12'h000, pa_q[51:32]};
            `LPW_OFS_STATUS: rdMux = statusWord;
            `LPW_OFS_INT_STAT: rdMux = {{(32-`LPW_INT_W){1'b0}}, intStat_q};
            `LPW_OFS_INT_MASK: rdMux = {{(32-`LPW_INT_W){1'b0}}, intMask_q};
            `LPW_OFS_QRY_FOURTH: rdMux = featWord;
            `LPW_OFS_QRY_FIRST: rdMux = `LPW_TLB_L1_GIGA;
            `LPW_OFS_QRY_SECOND: rdMux = `LPW_TLB_L2_GIGA;
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // bus phases and software writes
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            gigaEn_q <= `LPW_GIGA_EN_RST;
            base_q <= 40'h00_0000_0000;
            va_q <= 64'h0000_0000_0000_0000;
            intMask_q <= {`LPW_INT_W{1'b0}};
        end else begin
            wrPend_q <= addrPhase & hwrite;
            if (addrPhase) begin
                wrAddr_q <= haddr[7:0];
            end
            if (addrPhase & ~hwrite) begin
                hrdata_q <= rdMux;
            end
            if (wrPend_q) begin
                case (wrAddr_q)
                    `LPW_OFS_CTRL: gigaEn_q <= hwdata[`LPW_CTRL_GIGA_EN];
                    `LPW_OFS_BASE_LO: base_q[19:0] <= hwdata[31:12];
                    `LPW_OFS_BASE_HI: base_q[39:20] <= hwdata[19:0];
                    `LPW_OFS_VA_LO: begin
                        if (!busy) begin
                            va_q[31:0] <= hwdata;
                        end
                    end
                    `LPW_OFS_VA_HI: begin
                        if (!busy) begin
                            va_q[63:32] <= hwdata;
                        end
                    end
                    `LPW_OFS_INT_MASK: intMask_q <= hwdata[`LPW_INT_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // sticky interrupt bits, set wins over read clear
    assign intEvent = {evSmall, evGprot, evPage, evDone};

    generate
        for (gi = 0; gi < `LPW_INT_W; gi = gi + 1) begin : gIntBit
            assign intStat_d[gi] = intEvent[gi] | (intStat_q[gi] & ~intRdClr);
        end
    endgenerate

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            intStat_q <= {`LPW_INT_W{1'b0}};
        end else begin
            intStat_q <= intStat_d;
        end
    end

    // event decode from walk state and fetched entry
    always @* begin
        evDone = 1'b0;
        evPage = 1'b0;
        evGprot = 1'b0;
        evSmall = 1'b0;
        case (state_q)
            S_IDLE: begin
                evGprot = startPulse & ~canonical;
            end
            S_TOP: begin
                evPage = memAck & ~present;
            end
            S_PTR: begin
                evPage = memAck & ~present;
                evDone = memAck & present & sizeBit & gigaOk;
            end
            S_DIR: begin
                evPage = memAck & ~present;
                evDone = memAck & present & sizeBit;
                evSmall = memAck & present & ~sizeBit;
            end
            default: ;
        endcase
    end

    // walk state machine
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            memReq_q <= 1'b0;
            memAddr_q <= 52'h0_0000_0000_0000;
            pa_q <= 52'h0_0000_0000_0000;
            done_q <= 1'b0;
            size2m_q <= 1'b0;
            size1g_q <= 1'b0;
            fault_q <= `LPW_FLT_NONE;
            faultLvl_q <= `LPW_LVL_NONE;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (startPulse) begin
                        done_q <= 1'b0;
                        size2m_q <= 1'b0;
                        size1g_q <= 1'b0;
                        faultLvl_q <= `LPW_LVL_NONE;
                        if (!canonical) begin
                            fault_q <= `LPW_FLT_GPROT;
                            done_q <= 1'b1;
                        end else begin
                            fault_q <= `LPW_FLT_NONE;
                            memReq_q <= 1'b1;
                            memAddr_q <= {base_q, topIdx, 3'h0} & `LPW_PA_MASK;
                            state_q <= S_TOP;
                        end
                    end
                end
                S_TOP: begin
                    if (memAck) begin
                        if (!present) begin
                            fault_q <= `LPW_FLT_PAGE;
                            faultLvl_q <= `LPW_LVL_TOP;
                            done_q <= 1'b1;
                            memReq_q <= 1'b0;
                            state_q <= S_IDLE;
                        end else begin
                            memAddr_q <= nextPtr;
                            state_q <= S_PTR;
                        end
                    end
                end
                S_PTR: begin
                    if (memAck) begin
                        if (!present) begin
                            fault_q <= `LPW_FLT_PAGE;
                            faultLvl_q <= `LPW_LVL_PTR;
                            done_q <= 1'b1;
                            memReq_q <= 1'b0;
                            state_q <= S_IDLE;
                        end else if (sizeBit & gigaOk) begin
                            // last level, no directory fetch
                            pa_q <= pa1g;
                            size1g_q <= 1'b1;
                            done_q <= 1'b1;
                            memReq_q <= 1'b0;
                            state_q <= S_IDLE;
                        end else begin
                            memAddr_q <= nextDir;
                            state_q <= S_DIR;
                        end
                    end
                end
                S_DIR: begin
                    if (memAck) begin
                        memReq_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= S_IDLE;
                        if (!present) begin
                            fault_q <= `LPW_FLT_PAGE;
                            faultLvl_q <= `LPW_LVL_DIR;
                        end else if (sizeBit) begin
                            // last level, no leaf fetch
                            pa_q <= pa2m;
                            size2m_q <= 1'b1;
                        end else begin
                            // small pages not walked here, still no leaf fetch
                            fault_q <= `LPW_FLT_SMALL;
                            faultLvl_q <= `LPW_LVL_DIR;
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                    memReq_q <= 1'b0;
                end
            endcase
        end
    end
endmodule // lpw_walker

/* File: lpw_walker_assertions.sv */
`timescale 1ns/10ps
module lpw_walker_assertions (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // bus answer
    input wire hreadyout,
    input wire hresp,
    // table fetch link
    input wire memReq,
    input wire [51:0] memAddr,
    input wire memAck,
    input wire [63:0] memRdata
);
    logic [2:0] ackCnt_q;
    logic [2:0] ackCnt_d;
    // entries taken in the current walk
    assign ackCnt_d = !memReq ? 3'h0 : (memAck ? ackCnt_q + 3'h1 : ackCnt_q);
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ackCnt_q <= 3'h0;
        end else begin
            ackCnt_q <= ackCnt_d;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence s_fetched;
        memReq && memAck;
    endsequence
    sequence s_table_entry;
        s_fetched ##0 memRdata[0];
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_addr_implemented: assert property (memReq |-> memAddr[51:48] == 4'h0)
        else $error("fetch address beyond implemented bits");
    a_addr_aligned: assert property (memReq |-> memAddr[2:0] == 3'h0)
        else $error("fetch address not entry aligned");
    a_req_holds: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
        else $error("fetch request dropped before answer");
    a_next_base: assert property (s_table_entry ##1 memReq |-> memAddr[47:12] == $past(memRdata[47:12]))
        else $error("next table not taken from entry base");
    a_absent_stops: assert property (s_fetched ##0 !memRdata[0] |=> !memReq)
        else $error("walk went on past absent entry");
    a_three_fetches: assert property (ackCnt_q <= 3'h3)
        else $error("more than three fetches in a walk");
    a_dir_final: assert property (s_fetched ##0 (ackCnt_q == 3'h2) |=> !memReq)
        else $error("walk went below directory level");
endmodule // lpw_walker_assertions

bind lpw_walker lpw_walker_assertions i_lpw_walker_assertions (.clock(clock), .rst_n(rst_n),
    .hreadyout(hreadyout), .hresp(hresp), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
    .memRdata(memRdata));

/* File: lpw_mem_model.sv */
`timescale 1ns/10ps
module lpw_mem_model (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // table fetch link
    input wire memReq,
    input wire [51:0] memAddr,
    output logic memAck,
    output logic [63:0] memRdata,
    // answer delay in cycles
    input wire [3:0] ackDelay
);
    logic [63:0] mem [logic [51:0]];
    logic [3:0] waitCnt;
    int nFetch = 0;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            memAck <= 1'b0;
            memRdata <= 64'h0;
            waitCnt <= 4'h0;
        end else if (memReq && !memAck && waitCnt >= ackDelay) begin
            memAck <= 1'b1;
            memRdata <= mem.exists(memAddr) ? mem[memAddr] : 64'h0;
            waitCnt <= 4'h0;
            nFetch <= nFetch + 1;
        end else begin
            // data line is inverted every cycle outside the ack cycle
            memAck <= 1'b0;
            memRdata <= ~memRdata;
            waitCnt <= (memReq && !memAck) ? waitCnt + 4'h1 : 4'h0;
        end
    end
endmodule // lpw_mem_model

/* File: lpw_walker_tb.sv */
`timescale 1ns/10ps
`include "lpw_regs.vh"
module lpw_walker_tb;
    typedef struct {
        logic [63:0] va;
        logic [63:0] e0;
        logic [63:0] e1;
        logic [63:0] e2;
        logic giga;
        logic [3:0] flt;
        logic [1:0] sz;
        int nf;
    } lpw_row_t;
    localparam logic [63:0] VA = 64'h0000_1234_5678_9ABC;
    localparam logic [63:0] ET = 64'h0000_0000_0002_0001;
    localparam logic [63:0] EP = 64'h0000_0000_0003_0001;
    localparam logic [63:0] EG = 64'h0000_0001_C000_0081;
    localparam logic [63:0] ED = 64'h0004_0000_4060_0081;
    lpw_row_t rows [8];
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] ackDelay = 4'h0;
    wire hready, hreadyout, hresp, memReq, memAck, irq;
    wire [31:0] hrdata;
    wire [51:0] memAddr;
    wire [63:0] memRdata;
    logic [31:0] rd;
    logic [51:0] pa;
    int nErrors = 0;
    int numChecks = 0;
    assign hready = hreadyout;
    always #50 clock = ~clock;
    lpw_walker i_lpw_walker (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
        .memRdata(memRdata), .irq(irq));
    lpw_mem_model i_lpw_mem_model (.clock(clock), .rst_n(rst_n), .memReq(memReq), .memAddr(memAddr),
        .memAck(memAck), .memRdata(memRdata), .ackDelay(ackDelay));
    task automatic stopTest;
        if (nErrors == 0 && numChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic walk(input lpw_row_t r, input logic poke);
        int n;
        int f0;
        n = 0;
        i_lpw_mem_model.mem.delete();
        i_lpw_mem_model.mem[{40'h10, r.va[47:39], 3'h0}] = r.e0;
        i_lpw_mem_model.mem[{r.e0[51:12], r.va[38:30], 3'h0} & `LPW_PA_MASK] = r.e1;
        i_lpw_mem_model.mem[{r.e1[51:12], r.va[29:21], 3'h0} & `LPW_PA_MASK] = r.e2;
        f0 = i_lpw_mem_model.nFetch;
        bus(`LPW_OFS_VA_LO, 1'b1, r.va[31:0]);
        bus(`LPW_OFS_VA_HI, 1'b1, r.va[63:32]);
        bus(`LPW_OFS_CTRL, 1'b1, {30'h0, r.giga, 1'b1});
        if (poke) begin
            bus(`LPW_OFS_VA_HI, 1'b1, 32'h0001_0000);
        end
        @(posedge clock);
        do begin
            bus(`LPW_OFS_STATUS, 1'b0, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 300);
        check(64'(rd[7:1]), 64'({r.flt, r.sz, 1'b1}));
        check(64'(rd[9:8]), (r.flt == 4'h1 || r.flt == 4'h3) ? 64'(4 - r.nf) : 64'h0);
        check(64'(i_lpw_mem_model.nFetch - f0), 64'(r.nf));
        if (r.flt == 4'h0) begin
            pa = (r.sz[0] ? {r.e2[51:21], r.va[20:0]} : {r.e1[51:30], r.va[29:0]}) & `LPW_PA_MASK;
            bus(`LPW_OFS_PA_LO, 1'b0, 32'h0);
            check(64'(rd), 64'(pa[31:0]));
            bus(`LPW_OFS_PA_HI, 1'b0, 32'h0);
            check(64'(rd[19:0]), 64'(pa[51:32]));
        end
    endtask
    initial begin
        #2000000;
        nErrors++;
        stopTest;
    end
    initial begin
        rows[0] = '{VA, ET, EP, ED, 1'b1, 4'h0, 2'h1, 3};
        rows[1] = '{VA, ET, EG, ED, 1'b1, 4'h0, 2'h2, 2};
        rows[2] = '{VA, ET, EG, ED, 1'b0, 4'h0, 2'h1, 3};
        rows[3] = '{64'hFFFF_8765_4321_0FED, ET, EP, ED, 1'b1, 4'h0, 2'h1, 3};
        rows[4] = '{VA, 64'h0, EP, ED, 1'b1, 4'h1, 2'h0, 1};
        rows[5] = '{VA, ET, EP, ED & ~64'h1, 1'b1, 4'h1, 2'h0, 3};
        rows[6] = '{64'h0001_0000_0000_0000, ET, EP, ED, 1'b1, 4'h2, 2'h0, 0};
        rows[7] = '{VA, ET, EP, 64'h0000_0000_4060_0001, 1'b1, 4'h3, 2'h0, 3};
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check(64'({memReq, irq}), 64'h0);
        bus(`LPW_OFS_CTRL, 1'b0, 32'h0);
        check(64'(rd), 64'h2);
        bus(`LPW_OFS_QRY_FOURTH, 1'b0, 32'h0);
        check(64'(rd[26]), 64'h1);
        bus(`LPW_OFS_QRY_FIRST, 1'b0, 32'h0);
        check(64'(rd), 64'(`LPW_TLB_L1_GIGA));
        bus(`LPW_OFS_QRY_SECOND, 1'b0, 32'h0);
        check(64'(rd), 64'(`LPW_TLB_L2_GIGA));
        bus(8'h40, 1'b0, 32'h0);
        check(64'(rd), 64'h0);
        bus(`LPW_OFS_BASE_LO, 1'b1, 32'h0001_0000);
        bus(`LPW_OFS_BASE_HI, 1'b1, 32'h0);
        for (int i = 0; i < 8; i++) begin
            ackDelay <= 4'(i * 2);
            walk(rows[i], 1'b0);
        end
        bus(`LPW_OFS_INT_STAT, 1'b0, 32'h0);
        check(64'(rd[3:0]), 64'hF);
        bus(`LPW_OFS_INT_STAT, 1'b0, 32'h0);
        check(64'(rd[3:0]), 64'h0);
        bus(`LPW_OFS_INT_MASK, 1'b1, 32'h1);
        ackDelay <= 4'h8;
        // address change while busy must not disturb the walk
        walk(rows[0], 1'b1);
        check(64'(irq), 64'h1);
        bus(`LPW_OFS_INT_STAT, 1'b0, 32'h0);
        @(posedge clock);
        check(64'(irq), 64'h0);
        walk(rows[4], 1'b0);
        check(64'(irq), 64'h0);
        bus(`LPW_OFS_INT_MASK, 1'b1, 32'h2);
        @(posedge clock);
        check(64'(irq), 64'h1);
        bus(`LPW_OFS_INT_STAT, 1'b0, 32'h0);
        @(posedge clock);
        check(64'(irq), 64'h0);
        // reset in mid walk drops the request and restores reset values
        ackDelay <= 4'hE;
        bus(`LPW_OFS_CTRL, 1'b1, 32'h3);
        @(posedge clock);
        check(64'(memReq), 64'h1);
        rst_n <= 1'b0;
        @(posedge clock);
        check(64'({memReq, memAck, irq}), 64'h0);
        rst_n <= 1'b1;
        @(posedge clock);
        bus(`LPW_OFS_STATUS, 1'b0, 32'h0);
        check(64'(rd), 64'h0);
        bus(`LPW_OFS_CTRL, 1'b0, 32'h0);
        check(64'(rd), 64'h2);
        stopTest;
    end
endmodule // lpw_walker_tb
